// ==== hw/serial_status_pkg.sv ====
package serial_status_pkg;

   // register map, byte offsets on the plain register port
   localparam logic [2:0] ADDR_STATUS = 3'h0;
   localparam logic [2:0] ADDR_RATE = 3'h1;
   localparam logic [2:0] ADDR_CONTROL = 3'h2;
   localparam logic [2:0] ADDR_MODE = 3'h3;
   localparam logic [2:0] ADDR_TX_DATA = 3'h4;
   localparam logic [2:0] ADDR_RX_DATA = 3'h5;

   // status bit positions
   localparam int BIT_TX_EMPTY = 7;
   localparam int BIT_RX_FULL = 6;
   localparam int BIT_OVERRUN = 5;
   localparam int BIT_FRAMING = 4;
   localparam int BIT_PARITY = 3;
   localparam int BIT_TX_END = 2;
   localparam int BIT_RX_MPB = 1;
   localparam int BIT_TX_MPB = 0;

   // control and mode bit positions
   localparam int BIT_TX_ENABLE = 5;
   localparam int BIT_RX_ENABLE = 4;
   localparam int BIT_SYNC_MODE = 7;

   // reset values
   localparam logic [7:0] STATUS_RESET = 8'h84;
   localparam logic [7:0] RATE_RESET = 8'hFF;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;

   // prescale base in system clocks per bit: async 64, sync 8
   localparam int ASYNC_BASE = 64;
   localparam int SYNC_BASE = 8;
   localparam logic [11:0] ASYNC_HALF = 12'(ASYNC_BASE / 2);
   localparam logic [11:0] SYNC_HALF = 12'(SYNC_BASE / 2);

   typedef struct packed {
      logic tx_load;
      logic tx_last_bit;
      logic rx_done_ok;
      logic rx_overrun;
      logic rx_framing;
      logic rx_parity;
      logic rx_mpb;
   } engine_events_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// ==== hw/rate_tick_gen.sv ====
`timescale 1ns/10ps
`default_nettype none

// bit rate tick: one pulse every base * 2^(2n-1) * (N+1) clocks
module rate_tick_gen
   import serial_status_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] divisor_i,
   input wire logic [1:0] clk_select_i,
   input wire logic sync_mode_i,
   output logic tick_o
);

   logic [11:0] pre_q, pre_d;
   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic [11:0] pre_top;

   // base*2^(2n-1) = (base/2) << 2n
   always_comb
   begin
      pre_top = (sync_mode_i ? SYNC_HALF : ASYNC_HALF) << {clk_select_i, 1'b0};
      pre_d = pre_q + 12'h001;
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (pre_q >= pre_top - 12'h001)
      begin
         pre_d = 12'h000;
         if (cnt_q >= divisor_i)
         begin
            cnt_d = '0;
            tick_d = 1'b1;
         end
         else
         begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pre_q <= 12'h000;
         cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;

endmodule // rate_tick_gen

`default_nettype wire

// ==== hw/serial_port_status_and_rate.sv ====
`timescale 1ns/10ps
`default_nettype none

// Operation
// - writing one never sets the clearable flags
// - tx empty resets 1, sets on load/disable
// - tx empty clears on read-then-zero or data
// - rx full resets 0, sets on good reception
// - rx full clears on read-then-zero or read
// - overrun set on overrun, read-then-zero clears
// - framing set on framing error, same clear
// - parity set on parity error, same clear
// - tx end resets 1, disabled or last bit while empty
// - tx end clears on read-then-zero or data
// - rx multiproc bit captured, held when disabled
// - tx multiproc bit writable, sent with data
// - eight bit rate divisor, resets all ones
// - rate is clock over base times prescale times (N+1)
// - tx and rx enable bits reset zero
module serial_port_status_and_rate
   import serial_status_pkg::*;
#(
   parameter int RATE_WIDTH = 8
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire serial_status_pkg::engine_events_t events_i,
   input wire logic [7:0] rx_data_i,
   output logic tx_enable_o,
   output logic rx_enable_o,
   output logic tx_multiproc_bit_o,
   output logic [7:0] tx_data_o,
   output logic tx_data_valid_o,
   output logic [RATE_WIDTH-1:0] bit_rate_divisor_o,
   output logic [1:0] clk_select_o,
   output logic rate_tick_o
);
   import serial_status_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // request decode

   reg_req_t req;
   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   function automatic logic hit(input reg_req_t r, input logic [2:0] a);
      hit = r.addr == a;
   endfunction

   logic wr_status, rd_status, wr_txd, rd_rxd;
   assign wr_status = req.wr && hit(req, ADDR_STATUS);
   assign rd_status = req.rd && hit(req, ADDR_STATUS);
   assign wr_txd = req.wr && hit(req, ADDR_TX_DATA);
   assign rd_rxd = req.rd && hit(req, ADDR_RX_DATA);

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [RATE_WIDTH-1:0] rate_q, rate_d;
   logic [7:0] control_q, control_d;
   logic [7:0] mode_q, mode_d;
   logic [7:0] txd_q, txd_d;
   logic txv_q, txv_d;

   always_comb
   begin
      rate_d = rate_q;
      control_d = control_q;
      mode_d = mode_q;
      txd_d = txd_q;
      txv_d = 1'b0;
      if (req.wr && hit(req, ADDR_RATE))
         rate_d = req.wdata[RATE_WIDTH-1:0];
      if (req.wr && hit(req, ADDR_CONTROL))
         control_d = req.wdata;
      if (req.wr && hit(req, ADDR_MODE))
         mode_d = req.wdata;
      if (wr_txd)
      begin
         txd_d = req.wdata;
         txv_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rate_q <= RATE_WIDTH'(RATE_RESET);
         control_q <= CONTROL_RESET;
         mode_q <= MODE_RESET;
         txd_q <= 8'h00;
         txv_q <= 1'b0;
      end
      else
      begin
         rate_q <= rate_d;
         control_q <= control_d;
         mode_q <= mode_d;
         txd_q <= txd_d;
         txv_q <= txv_d;
      end
   end

   logic tx_en, rx_en;
   assign tx_en = control_q[BIT_TX_ENABLE];
   assign rx_en = control_q[BIT_RX_ENABLE];

   ////////////////////////////////////////////////////////////////////////
   // status flags

   // clearable flags in bits 7..2, armed mask remembers a read as one
   logic [7:2] flag_q, flag_d;
   logic [7:2] armed_q, armed_d;
   logic rx_multiproc_q, rx_multiproc_d;
   logic tx_multiproc_q, tx_multiproc_d;
   logic [7:2] set_v, clr_v;

   always_comb
   begin
      set_v = '0;
      set_v[BIT_TX_EMPTY] = !tx_en || events_i.tx_load;
      set_v[BIT_RX_FULL] = events_i.rx_done_ok;
      set_v[BIT_OVERRUN] = events_i.rx_overrun;
      set_v[BIT_FRAMING] = events_i.rx_framing;
      set_v[BIT_PARITY] = events_i.rx_parity;
      set_v[BIT_TX_END] = !tx_en ||
         (events_i.tx_last_bit && flag_q[BIT_TX_EMPTY]);
      // a zero written to an armed bit clears; ones are ignored
      clr_v = '0;
      if (wr_status)
         clr_v = ~req.wdata[7:2] & armed_q;
      clr_v[BIT_TX_EMPTY] = clr_v[BIT_TX_EMPTY] || wr_txd;
      clr_v[BIT_TX_END] = clr_v[BIT_TX_END] || wr_txd;
      clr_v[BIT_RX_FULL] = clr_v[BIT_RX_FULL] || rd_rxd;
      flag_d = set_v | (flag_q & ~clr_v);
      armed_d = armed_q & ~clr_v & flag_d;
      if (rd_status)
         armed_d = armed_d | flag_q;
      rx_multiproc_d = rx_multiproc_q;
      if (rx_en && events_i.rx_done_ok)
         rx_multiproc_d = events_i.rx_mpb;
      tx_multiproc_d = tx_multiproc_q;
      if (wr_status)
         tx_multiproc_d = req.wdata[BIT_TX_MPB];
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         flag_q <= STATUS_RESET[7:2];
         armed_q <= '0;
         rx_multiproc_q <= 1'b0;
         tx_multiproc_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
         armed_q <= armed_d;
         rx_multiproc_q <= rx_multiproc_d;
         tx_multiproc_q <= tx_multiproc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, valid only in the cycle after the strobe

   logic [7:0] rdata_q, rdata_d;

   always_comb
   begin
      rdata_d = 8'h00;
      if (req.rd)
      begin
         case (req.addr)
            ADDR_STATUS: rdata_d = {flag_q, rx_multiproc_q, tx_multiproc_q};
            ADDR_RATE: rdata_d = 8'(rate_q);
            ADDR_CONTROL: rdata_d = control_q;
            ADDR_MODE: rdata_d = mode_q;
            ADDR_TX_DATA: rdata_d = txd_q;
            ADDR_RX_DATA: rdata_d = rx_data_i;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // bit rate generator

   logic tick;

   rate_tick_gen #(
      .WIDTH(RATE_WIDTH)
   ) u_rate (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .divisor_i(rate_q),
      .clk_select_i(mode_q[1:0]),
      .sync_mode_i(mode_q[BIT_SYNC_MODE]),
      .tick_o(tick)
   );

   assign rdata_o = rdata_q;
   assign tx_enable_o = tx_en;
   assign rx_enable_o = rx_en;
   assign tx_multiproc_bit_o = tx_multiproc_q;
   assign tx_data_o = txd_q;
   assign tx_data_valid_o = txv_q;
   assign bit_rate_divisor_o = rate_q;
   assign clk_select_o = mode_q[1:0];
   assign rate_tick_o = tick;

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_write_one_ignored: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_status && !flag_q[BIT_OVERRUN] && !events_i.rx_overrun)
      |=> !flag_q[BIT_OVERRUN])
      else $error("overrun flag set by a write");

   a_tx_empty_disabled: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !tx_en |=> flag_q[BIT_TX_EMPTY] && flag_q[BIT_TX_END])
      else $error("tx flags not set while disabled");

   a_tx_data_clears: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_txd && tx_en && !events_i.tx_load && !events_i.tx_last_bit)
      |=> !flag_q[BIT_TX_EMPTY] && !flag_q[BIT_TX_END] && txv_q)
      else $error("tx data write did not clear flags");

   a_rx_full_sets: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      events_i.rx_done_ok |=> flag_q[BIT_RX_FULL])
      else $error("rx full not set");

   a_rx_read_clears: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (rd_rxd && !events_i.rx_done_ok) |=> !flag_q[BIT_RX_FULL])
      else $error("rx data read did not clear rx full");

   a_unarmed_keeps: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_status && !armed_q[BIT_FRAMING] && flag_q[BIT_FRAMING])
      |=> flag_q[BIT_FRAMING])
      else $error("framing flag cleared without prior read");

   a_armed_clears: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (rd_status && flag_q[BIT_OVERRUN] ##1
       wr_status && !req.wdata[BIT_OVERRUN] && !events_i.rx_overrun)
      |=> !flag_q[BIT_OVERRUN])
      else $error("overrun not cleared after read then zero");

   a_rx_multiproc_held: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !rx_en |=> $stable(rx_multiproc_q))
      else $error("rx multiproc bit changed while disabled");

   a_rate_write: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (req.wr && hit(req, ADDR_RATE)) |=> rate_q == $past(req.wdata))
      else $error("rate register not written");

   a_read_latency: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (req.rd && hit(req, ADDR_STATUS))
      |=> rdata_o[BIT_TX_MPB] == tx_multiproc_q)
      else $error("status read data wrong");

   a_tx_end_held: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (tx_en && !flag_q[BIT_TX_END] &&
       !(events_i.tx_last_bit && flag_q[BIT_TX_EMPTY]))
      |=> !flag_q[BIT_TX_END])
      else $error("tx end set without last bit while empty");

   a_multiproc_capture: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (rx_en && events_i.rx_done_ok)
      |=> rx_multiproc_q == $past(events_i.rx_mpb))
      else $error("rx multiproc bit not captured");

   a_set_beats_clear: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_status && events_i.rx_framing) |=> flag_q[BIT_FRAMING])
      else $error("framing clear won over a same cycle set");

endmodule // serial_port_status_and_rate

`default_nettype wire

// ==== tb/remote_station.sv ====
`timescale 1ns/10ps
`default_nettype none

// stands in for the shift engines: one-cycle event pulses, holding register
module remote_station
   import serial_status_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire serial_status_pkg::engine_events_t req_i,
   input wire logic [7:0] byte_i,
   output serial_status_pkg::engine_events_t events_o,
   output logic [7:0] rx_data_o
);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         events_o <= '0;
         rx_data_o <= 8'h00;
      end
      else
      begin
         events_o <= req_i;
         // holding register only moves on a good reception
         if (req_i.rx_done_ok)
            rx_data_o <= byte_i;
      end
   end
endmodule // remote_station

`default_nettype wire

// ==== tb/serial_port_status_and_rate_test.sv ====
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("BAD %0t mismatch got %h exp %h", $time, a, e); end end

module serial_port_status_and_rate_test;
   import serial_status_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   engine_events_t req = '0;
   engine_events_t events;
   logic [7:0] rx_byte = 8'h00;
   logic [7:0] rx_data, rdata, tx_data, rate;
   logic tx_en, rx_en, tx_mpb, tx_valid, tick;
   logic [1:0] csel;
   logic [7:0] d;
   int p;
   int fail_count = 0;
   int total_checks = 0;

   always #5 clk_i = ~clk_i;

   serial_port_status_and_rate uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .events_i(events), .rx_data_i(rx_data), .tx_enable_o(tx_en),
      .rx_enable_o(rx_en), .tx_multiproc_bit_o(tx_mpb), .tx_data_o(tx_data),
      .tx_data_valid_o(tx_valid), .bit_rate_divisor_o(rate),
      .clk_select_o(csel), .rate_tick_o(tick));

   remote_station station (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
      .byte_i(rx_byte), .events_o(events), .rx_data_o(rx_data));

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      #1;
   endtask

   task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 d = rdata;
      `CHK(d, e)
   endtask

   // read then write back to back, read data checked while it stands
   task automatic rd_wr(input logic [2:0] a, input logic [7:0] e,
      input logic [7:0] v);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      wdata <= v;
      wr <= 1'b1;
      #1 d = rdata;
      `CHK(d, e)
      @(posedge clk_i);
      wr <= 1'b0;
      #1;
   endtask

   // event pulse lands in the status two edges after it is requested
   task automatic fire(input engine_events_t e, input logic [7:0] b);
      @(posedge clk_i);
      req <= e;
      rx_byte <= b;
      @(posedge clk_i);
      req <= '0;
      @(posedge clk_i);
      #1;
   endtask

   // first wait finds a tick, second counts one full period
   task automatic meas;
      for (int i = 0; i < 2; i++)
      begin
         p = 0;
         do
         begin
            @(posedge clk_i);
            #1;
            p++;
         end
         while (tick !== 1'b1 && p < 600);
         if (tick !== 1'b1)
         begin
            fail_count++;
            close_out();
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk_rd(ADDR_STATUS, 8'h84);
      chk_rd(ADDR_RATE, 8'hFF);
      chk_rd(ADDR_CONTROL, 8'h00);
      wr_reg(3'h6, 8'h5A);
      chk_rd(3'h6, 8'h00);
      $display("done reset values");
   endtask

   task automatic t_status_write;
      wr_reg(ADDR_STATUS, 8'hFF);
      `CHK(tx_mpb, 1'b1)
      chk_rd(ADDR_STATUS, 8'h85);
      wr_reg(ADDR_STATUS, 8'h00);
      `CHK(tx_mpb, 1'b0)
      chk_rd(ADDR_STATUS, 8'h84);
      $display("done status write");
   endtask

   task automatic t_tx;
      wr_reg(ADDR_CONTROL, 8'h20);
      `CHK(tx_en, 1'b1)
      wr_reg(ADDR_TX_DATA, 8'h5A);
      `CHK(tx_valid, 1'b1)
      `CHK(tx_data, 8'h5A)
      chk_rd(ADDR_STATUS, 8'h00);
      fire(7'h20, 8'h00);
      chk_rd(ADDR_STATUS, 8'h00);
      fire(7'h40, 8'h00);
      chk_rd(ADDR_STATUS, 8'h80);
      fire(7'h20, 8'h00);
      chk_rd(ADDR_STATUS, 8'h84);
      wr_reg(ADDR_STATUS, 8'h7E);
      chk_rd(ADDR_STATUS, 8'h04);
      wr_reg(ADDR_STATUS, 8'hFA);
      chk_rd(ADDR_STATUS, 8'h00);
      wr_reg(ADDR_CONTROL, 8'h00);
      chk_rd(ADDR_STATUS, 8'h84);
      $display("done transmit flags");
   endtask

   task automatic t_rx;
      wr_reg(ADDR_CONTROL, 8'h10);
      `CHK(rx_en, 1'b1)
      fire(7'h11, 8'hC3);
      chk_rd(ADDR_STATUS, 8'hC6);
      chk_rd(ADDR_RX_DATA, 8'hC3);
      chk_rd(ADDR_STATUS, 8'h86);
      fire(7'h10, 8'h3C);
      chk_rd(ADDR_STATUS, 8'hC4);
      wr_reg(ADDR_STATUS, 8'hBC);
      chk_rd(ADDR_STATUS, 8'h84);
      fire(7'h0E, 8'h00);
      wr_reg(ADDR_STATUS, 8'h00);
      rd_wr(ADDR_STATUS, 8'hBC, 8'hDC);
      chk_rd(ADDR_STATUS, 8'h9C);
      // framing sets in the same cycle as the clearing write
      @(posedge clk_i);
      req <= 7'h04;
      @(posedge clk_i);
      req <= '0;
      addr <= ADDR_STATUS;
      wdata <= 8'h00;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      chk_rd(ADDR_STATUS, 8'h94);
      wr_reg(ADDR_STATUS, 8'hEC);
      chk_rd(ADDR_STATUS, 8'h84);
      fire(7'h11, 8'h00);
      wr_reg(ADDR_CONTROL, 8'h00);
      fire(7'h10, 8'h00);
      chk_rd(ADDR_STATUS, 8'hC6);
      `CHK(d[1], 1'b1)
      $display("done receive flags");
   endtask

   task automatic t_rate;
      wr_reg(ADDR_RATE, 8'h02);
      chk_rd(ADDR_RATE, 8'h02);
      wr_reg(ADDR_MODE, 8'h80);
      meas();
      `CHK(p, 12)
      `CHK(csel, 2'h0)
      wr_reg(ADDR_RATE, 8'h01);
      wr_reg(ADDR_MODE, 8'h01);
      meas();
      `CHK(p, 256)
      `CHK(csel, 2'h1)
      `CHK(rate, 8'h01)
      $display("done bit rate");
   endtask

   // reset again in mid-run, after rate and status have moved
   task automatic t_rerun;
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      chk_rd(ADDR_RATE, 8'hFF);
      chk_rd(ADDR_STATUS, 8'h84);
      chk_rd(ADDR_CONTROL, 8'h00);
      $display("done mid-run reset");
   endtask

   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_status_write();
      t_tx();
      t_rx();
      t_rate();
      t_rerun();
      close_out();
   end
endmodule // serial_port_status_and_rate_test

`default_nettype wire
